/* logic/eil_top.sv */
// External interrupt latch with AXI4-Lite status and control registers
// What this block does
// - A falling edge on the request pin sets the interrupt latch.
// - A vector fetch acknowledge clears the latch that caused it.
// - Writing one to the acknowledge bit clears the latch.
// - Reset clears latch and sensitivity select even with pin low.
// - Edge-only after reset; software picks edge-only or edge-plus-low-level.
// - Select at zero: latch held until acknowledge or reset, then cleared.
// - Select at one: pending until acknowledge and pin high, any order.
// - Acknowledge leaves later edges alone; a later falling edge relatches.
// - Module mask set keeps the request from the priority logic.
// - The addresses of the two vector bytes are given out for the program counter load.
// - Pending flag is read-only, shows pending, ignores the mask.
// - Acknowledge bit is write-only, reads zero, reset clears it.
// - Module mask is read/write, one disables, reset clears.
// - Select bit is read/write, one adds low level, reset clears.
// - In break with clear-enable one, acknowledge clears; stays cleared after.
// - In break with clear-enable zero, acknowledge writes do nothing.
// - The CPU global interrupt mask also blocks the request.
// - Pin level is offered to the branch-on-pin instructions.
//
// Local design decisions: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ns
module eil_top #(
	parameter int DATA_W = 32
) (
	// Clock and reset
	input wire logic CLOCK_I,
	input wire logic SYS_RST_I,
	// External request pin, active low
	input wire logic IRQ_PIN_N_I,
	// CPU core side
	input wire logic VECTOR_FETCH_I,
	input wire logic BREAK_STATE_I,
	// Request to the priority logic, vector, pin level
	output logic IRQ_REQ_O,
	output logic [15:0] VEC_HIGH_ADDR_O,
	output logic [15:0] VEC_LOW_ADDR_O,
	output logic PIN_LEVEL_O,
	// AXI4-Lite write address
	input wire logic [eil_pkg::ADDR_W-1:0] S_AXI_AWADDR,
	input wire logic S_AXI_AWVALID,
	output logic S_AXI_AWREADY,
	// AXI4-Lite write data
	input wire logic [31:0] S_AXI_WDATA,
	input wire logic [3:0] S_AXI_WSTRB,
	input wire logic S_AXI_WVALID,
	output logic S_AXI_WREADY,
	// AXI4-Lite write response
	output logic [1:0] S_AXI_BRESP,
	output logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	// AXI4-Lite read address
	input wire logic [eil_pkg::ADDR_W-1:0] S_AXI_ARADDR,
	input wire logic S_AXI_ARVALID,
	output logic S_AXI_ARREADY,
	// AXI4-Lite read data
	output logic [31:0] S_AXI_RDATA,
	output logic [1:0] S_AXI_RRESP,
	output logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY
);
	// Only a 32-bit register bus is served
	if (DATA_W != 32) begin : g_chk
		$error("eil_top: DATA_W must be 32");
	end

	eil_pkg::eil_state_s s_reg;
	eil_pkg::eil_state_s s_next;

	// Vector locations are constants
	assign VEC_HIGH_ADDR_O = eil_pkg::VEC_HIGH_ADDR;
	assign VEC_LOW_ADDR_O = eil_pkg::VEC_LOW_ADDR;

	// Outputs from the state register; the write readies are gated from it
	assign IRQ_REQ_O = s_reg.req;
	assign PIN_LEVEL_O = s_reg.pin_level;
	assign S_AXI_AWREADY = ~s_reg.aw_got & (s_reg.wr_st == eil_pkg::WR_IDLE);
	assign S_AXI_WREADY = ~s_reg.w_got & (s_reg.wr_st == eil_pkg::WR_IDLE);
	assign S_AXI_BVALID = s_reg.bvalid;
	assign S_AXI_BRESP = s_reg.bresp;
	assign S_AXI_ARREADY = s_reg.arready;
	assign S_AXI_RVALID = s_reg.rvalid;
	assign S_AXI_RDATA = s_reg.rdata;
	assign S_AXI_RRESP = s_reg.rresp;

	// Next-state logic
	always_comb begin
		logic do_write;
		logic ack;
		logic ack_ok;
		logic fall;
		logic low;
		logic [31:0] rd;
		logic rd_ok;
		logic pend;
		do_write = 1'b0;
		pend = 1'b0;
		ack = 1'b0;
		ack_ok = 1'b0;
		fall = 1'b0;
		low = 1'b0;
		rd = 32'h0;
		rd_ok = 1'b1;
		s_next = s_reg;

		// Pin synchroniser and edge detect
		s_next.pin_s1 = IRQ_PIN_N_I;
		s_next.pin_s2 = s_reg.pin_s1;
		s_next.pin_prev = s_reg.pin_s2;
		fall = s_reg.pin_prev & ~s_reg.pin_s2;
		low = ~s_reg.pin_s2;
		s_next.pin_level = s_reg.pin_s2;

		// Write address and data taken in either order
		if (S_AXI_AWVALID && S_AXI_AWREADY) begin
			s_next.aw_got = 1'b1;
			s_next.aw_addr = S_AXI_AWADDR;
		end
		if (S_AXI_WVALID && S_AXI_WREADY) begin
			s_next.w_got = 1'b1;
			s_next.w_data = S_AXI_WDATA;
			s_next.w_strb = S_AXI_WSTRB;
		end

		// Write execution and response
		case (s_reg.wr_st)
			eil_pkg::WR_IDLE: begin
				if (s_reg.aw_got && s_reg.w_got) begin
					do_write = 1'b1;
					s_next.aw_got = 1'b0;
					s_next.w_got = 1'b0;
					s_next.bvalid = 1'b1;
					s_next.bresp = eil_pkg::RESP_OKAY;
					s_next.wr_st = eil_pkg::WR_RESP;
				end
			end
			eil_pkg::WR_RESP: begin
				if (S_AXI_BREADY) begin
					s_next.bvalid = 1'b0;
					s_next.wr_st = eil_pkg::WR_IDLE;
				end
			end
			default: begin
				s_next.wr_st = eil_pkg::WR_IDLE;
				s_next.bvalid = 1'b0;
			end
		endcase

		// Register writes, low byte lane only
		if (do_write) begin
			if (!s_reg.w_strb[0]) begin
				// Low byte lane not enabled: nothing stored
			end else if (s_reg.aw_addr == eil_pkg::OFF_STATUS_CONTROL) begin
				s_next.mode = s_reg.w_data[eil_pkg::FLD_MODE];
				s_next.mask = s_reg.w_data[eil_pkg::FLD_MASK];
				ack = s_reg.w_data[eil_pkg::FLD_ACK];
			end else if (s_reg.aw_addr == eil_pkg::OFF_BREAK_CONTROL) begin
				s_next.break_clear_enable = s_reg.w_data[eil_pkg::FLD_BREAK_CLEAR_ENABLE];
			end else if (s_reg.aw_addr == eil_pkg::OFF_CPU_CONTROL) begin
				s_next.ibit = s_reg.w_data[eil_pkg::FLD_IBIT];
			end else begin
				s_next.bresp = eil_pkg::RESP_SLVERR;
			end
		end

		// Software acknowledge gated in break state
		ack_ok = ack & (~BREAK_STATE_I | s_reg.break_clear_enable);
		// Any acknowledge clears the latch unless a new edge wins
		if (VECTOR_FETCH_I || ack_ok) begin
			s_next.latch = 1'b0;
		end
		// Fresh falling edge latches regardless of acknowledge
		if (fall) begin
			s_next.latch = 1'b1;
		end
		// Level mode: pending while latched or pin low, so ack and release in any order
		pend = s_reg.latch | (s_reg.mode & low);

		// Request toward priority logic
		s_next.req = pend & ~s_reg.mask & ~s_reg.ibit;

		// Read channel
		s_next.arready = 1'b0;
		if (s_reg.rvalid) begin
			if (S_AXI_RREADY) begin
				s_next.rvalid = 1'b0;
			end
		end else if (S_AXI_ARVALID && !s_reg.arready) begin
			s_next.arready = 1'b1;
			case (S_AXI_ARADDR)
				eil_pkg::OFF_STATUS_CONTROL: begin
					rd[eil_pkg::FLD_MODE] = s_reg.mode;
					rd[eil_pkg::FLD_MASK] = s_reg.mask;
					rd[eil_pkg::FLD_ACK] = 1'b0;
					rd[eil_pkg::FLD_FLAG] = pend;
				end
				eil_pkg::OFF_BREAK_CONTROL: begin
					rd[eil_pkg::FLD_BREAK_CLEAR_ENABLE] = s_reg.break_clear_enable;
				end
				eil_pkg::OFF_CPU_CONTROL: begin
					rd[eil_pkg::FLD_BREAK] = BREAK_STATE_I;
					rd[eil_pkg::FLD_IBIT] = s_reg.ibit;
					rd[eil_pkg::FLD_PIN] = s_reg.pin_level;
				end
				default: begin
					rd_ok = 1'b0;
				end
			endcase
			s_next.rvalid = 1'b1;
			s_next.rdata = rd;
			s_next.rresp = rd_ok ? eil_pkg::RESP_OKAY : eil_pkg::RESP_SLVERR;
		end

		// Synchronous reset; pin chain keeps tracking so a held-low pin gives no false edge
		if (SYS_RST_I) begin
			s_next = '0;
			s_next.pin_s1 = IRQ_PIN_N_I;
			s_next.pin_s2 = s_reg.pin_s1;
			s_next.pin_prev = s_reg.pin_s2;
			s_next.pin_level = 1'b1;
			s_next.latch = 1'b0;
			s_next.mode = eil_pkg::RST_MODE;
			s_next.mask = eil_pkg::RST_MASK;
			s_next.break_clear_enable = eil_pkg::RST_BREAK_CLEAR_ENABLE;
			s_next.ibit = eil_pkg::RST_IBIT;
			s_next.wr_st = eil_pkg::WR_IDLE;
		end
	end

	// State register
	always_ff @(posedge CLOCK_I) begin
		s_reg <= s_next;
	end
endmodule // eil_top

/* logic/eil_pkg.sv */
// Package for the external interrupt latch: register map, fields, types
package eil_pkg;
	// Register byte offsets on the AXI4-Lite bus
	localparam logic [3:0] OFF_STATUS_CONTROL = 4'h0;
	localparam logic [3:0] OFF_BREAK_CONTROL = 4'h4;
	localparam logic [3:0] OFF_CPU_CONTROL = 4'h8;
	localparam int ADDR_W = 4;
	// Status and control field positions
	localparam int FLD_MODE = 0;
	localparam int FLD_MASK = 1;
	localparam int FLD_ACK = 2;
	localparam int FLD_FLAG = 3;
	// Break control field positions
	localparam int FLD_BREAK_CLEAR_ENABLE = 7;
	// CPU side control field positions
	localparam int FLD_VFETCH = 0;
	localparam int FLD_BREAK = 1;
	localparam int FLD_IBIT = 2;
	localparam int FLD_PIN = 3;
	// Reset values
	localparam logic RST_MODE = 1'b0;
	localparam logic RST_MASK = 1'b0;
	localparam logic RST_BREAK_CLEAR_ENABLE = 1'b0;
	localparam logic RST_IBIT = 1'b1;
	// Interrupt vector locations
	localparam logic [15:0] VEC_HIGH_ADDR = 16'hfffa;
	localparam logic [15:0] VEC_LOW_ADDR = 16'hfffb;
	// AXI response codes
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	// Write channel state
	typedef enum logic [1:0] {
		WR_IDLE = 2'b00,
		WR_RESP = 2'b01
	} eil_wr_e;

	// Whole state of the block
	typedef struct packed {
		logic pin_s1;
		logic pin_s2;
		logic pin_prev;
		logic latch;
		logic mode;
		logic mask;
		logic break_clear_enable;
		logic ibit;
		logic req;
		logic pin_level;
		logic aw_got;
		logic [ADDR_W-1:0] aw_addr;
		logic w_got;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		eil_wr_e wr_st;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} eil_state_s;
endpackage

/* tb/eil_props.sv */
// Port-level checker for the external interrupt latch
`timescale 1ns/1ns
module eil_props (
	// Clock, reset, pin side
	input wire logic CLOCK_I,
	input wire logic SYS_RST_I,
	input wire logic IRQ_PIN_N_I,
	input wire logic VECTOR_FETCH_I,
	input wire logic IRQ_REQ_O,
	input wire logic [15:0] VEC_HIGH_ADDR_O,
	input wire logic [15:0] VEC_LOW_ADDR_O,
	input wire logic PIN_LEVEL_O,
	// Bus handshakes
	input wire logic S_AXI_AWREADY,
	input wire logic S_AXI_WREADY,
	input wire logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	input wire logic S_AXI_ARREADY,
	input wire logic S_AXI_RVALID
);
	default clocking @(posedge CLOCK_I); endclocking
	default disable iff (SYS_RST_I);
	// Request side
	chk_fetch_clr: assert property (IRQ_PIN_N_I [*6] ##0 VECTOR_FETCH_I |-> ##2 !IRQ_REQ_O)
		else $error("request stayed after vector fetch");
	chk_rst_req: assert property ($fell(SYS_RST_I) |-> !IRQ_REQ_O)
		else $error("request seen right after reset");
	chk_vec_hi: assert property (VEC_HIGH_ADDR_O == 16'hfffa)
		else $error("wrong high vector address");
	chk_vec_lo: assert property (VEC_LOW_ADDR_O == 16'hfffb)
		else $error("wrong low vector address");
	chk_pin_hi: assert property (IRQ_PIN_N_I [*4] |-> PIN_LEVEL_O)
		else $error("pin level not high");
	chk_pin_lo: assert property (!IRQ_PIN_N_I [*4] |-> !PIN_LEVEL_O)
		else $error("pin level not low");
	// Bus side
	chk_aw_busy: assert property (S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY)
		else $error("write taken while responding");
	chk_b_done: assert property (S_AXI_BVALID && S_AXI_BREADY |=> !S_AXI_BVALID)
		else $error("write response not retired");
	chk_ar_pulse: assert property (S_AXI_ARREADY |-> S_AXI_RVALID ##1 !S_AXI_ARREADY)
		else $error("read address ready not a pulse");
endmodule // eil_props
bind eil_top eil_props eil_props_i (.CLOCK_I, .SYS_RST_I, .IRQ_PIN_N_I, .VECTOR_FETCH_I,
	.IRQ_REQ_O, .VEC_HIGH_ADDR_O, .VEC_LOW_ADDR_O, .PIN_LEVEL_O, .S_AXI_AWREADY,
	.S_AXI_WREADY, .S_AXI_BVALID, .S_AXI_BREADY, .S_AXI_ARREADY, .S_AXI_RVALID);

/* tb/eil_pin_drv.sv */
// Far-side circuit that pulls the request pin low
`timescale 1ns/1ns
module eil_pin_drv (
	// Clock and command
	input wire logic clk_i,
	input wire logic low_i,
	// Pin, pulled up while released
	output logic pin_n_o
);
	logic pin_reg = 1'b1;
	// Drive low on command, else the pull-up wins
	always @(posedge clk_i) begin
		pin_reg <= !low_i;
	end
	assign pin_n_o = pin_reg;
endmodule // eil_pin_drv

/* tb/tb_eil_top.sv */
// Self-checking bench for the external interrupt latch
`timescale 1ns/1ns
module tb_eil_top;
	logic clk = 1'b0, rst = 1'b1, low = 1'b0, vf = 1'b0, brk = 1'b0, pin_n;
	logic awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0;
	logic awr, wrd, bv, arr, rv, req, lvl;
	logic [3:0] awa = 4'h0, ara = 4'h0;
	logic [31:0] wd = 32'h0, rdat;
	logic [1:0] bresp, rresp;
	int num_errors = 0, checks = 0;
	// Clock
	always #2 clk = ~clk;
	eil_pin_drv eil_pin_drv_i (.clk_i(clk), .low_i(low), .pin_n_o(pin_n));
	eil_top eil_top_i (.CLOCK_I(clk), .SYS_RST_I(rst), .IRQ_PIN_N_I(pin_n),
		.VECTOR_FETCH_I(vf), .BREAK_STATE_I(brk), .IRQ_REQ_O(req), .VEC_HIGH_ADDR_O(),
		.VEC_LOW_ADDR_O(), .PIN_LEVEL_O(lvl), .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv),
		.S_AXI_AWREADY(awr), .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wv),
		.S_AXI_WREADY(wrd), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bv), .S_AXI_BREADY(br),
		.S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdat),
		.S_AXI_RRESP(rresp), .S_AXI_RVALID(rv), .S_AXI_RREADY(rr));
	// Verdict and stop
	task automatic end_sim();
		if (num_errors == 0 && checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	// Compare and count
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
		checks++;
		if (s !== e) begin
			num_errors++;
			$display("BAD %s exp %h got %h", n, e, s);
		end
	endtask
	// Bounded wait step
	task automatic tmo(inout int n);
		@(posedge clk);
		n++;
		if (n > 50) begin
			num_errors++;
			end_sim();
		end
	endtask
	task automatic cyc(input int k);
		repeat (k) @(posedge clk);
	endtask
	// Bus write, both channels offered together
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		awa <= a;
		wd <= d;
		awv <= 1'b1;
		wv <= 1'b1;
		br <= 1'b1;
		while (!bv) begin
			tmo(n);
			if (awr) awv <= 1'b0;
			if (wrd) wv <= 1'b0;
		end
		br <= 1'b0;
		chk("bresp", {30'h0, eil_pkg::RESP_OKAY}, {30'h0, bresp});
	endtask
	// Bus read with expected data and response
	task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic [1:0] er);
		int n;
		n = 0;
		@(posedge clk);
		ara <= a;
		arv <= 1'b1;
		rr <= 1'b1;
		while (!rv) begin
			tmo(n);
			if (arr) arv <= 1'b0;
		end
		rr <= 1'b0;
		chk("rdata", e, rdat);
		chk("rresp", {30'h0, er}, {30'h0, rresp});
	endtask
	task automatic st(input logic [31:0] e);
		rd(eil_pkg::OFF_STATUS_CONTROL, e, eil_pkg::RESP_OKAY);
	endtask
	// Reset values and unmapped place
	task automatic t_reset();
		st(32'h0);
		rd(eil_pkg::OFF_BREAK_CONTROL, 32'h0, eil_pkg::RESP_OKAY);
		rd(eil_pkg::OFF_CPU_CONTROL, 32'hc, eil_pkg::RESP_OKAY);
		rd(4'hc, 32'h0, eil_pkg::RESP_SLVERR);
	endtask
	// Global mask blocks, acknowledge clears with pin low
	task automatic t_ibit();
		low <= 1'b1;
		cyc(8);
		chk("req", 32'h0, {31'h0, req});
		st(32'h8);
		wr(eil_pkg::OFF_STATUS_CONTROL, 32'h4);
		st(32'h0);
		low <= 1'b0;
		wr(eil_pkg::OFF_CPU_CONTROL, 32'h0);
	endtask
	// Edge, acknowledge, new edge, vector fetch
	task automatic t_edge();
		low <= 1'b1;
		cyc(8);
		chk("req", 32'h1, {31'h0, req});
		wr(eil_pkg::OFF_STATUS_CONTROL, 32'h4);
		cyc(3);
		chk("req", 32'h0, {31'h0, req});
		low <= 1'b0;
		cyc(4);
		low <= 1'b1;
		cyc(8);
		chk("req", 32'h1, {31'h0, req});
		low <= 1'b0;
		cyc(8);
		vf <= 1'b1;
		cyc(1);
		vf <= 1'b0;
		cyc(3);
		chk("req", 32'h0, {31'h0, req});
	endtask
	// Module mask hides request, flag still shows it
	task automatic t_mask();
		wr(eil_pkg::OFF_STATUS_CONTROL, 32'h2);
		low <= 1'b1;
		cyc(8);
		chk("req", 32'h0, {31'h0, req});
		st(32'ha);
		wr(eil_pkg::OFF_STATUS_CONTROL, 32'h0);
		cyc(3);
		chk("req", 32'h1, {31'h0, req});
		wr(eil_pkg::OFF_STATUS_CONTROL, 32'h4);
		low <= 1'b0;
	endtask
	// Level mode: pending until ack and pin high
	task automatic t_mode1();
		wr(eil_pkg::OFF_STATUS_CONTROL, 32'h1);
		low <= 1'b1;
		cyc(8);
		wr(eil_pkg::OFF_STATUS_CONTROL, 32'h3);
		wr(eil_pkg::OFF_STATUS_CONTROL, 32'h7);
		st(32'hb);
		low <= 1'b0;
		cyc(6);
		st(32'h3);
		wr(eil_pkg::OFF_STATUS_CONTROL, 32'h0);
	endtask
	// Acknowledge during break, guarded then allowed
	task automatic t_brk();
		brk <= 1'b1;
		low <= 1'b1;
		cyc(8);
		wr(eil_pkg::OFF_STATUS_CONTROL, 32'h4);
		st(32'h8);
		wr(eil_pkg::OFF_BREAK_CONTROL, 32'h80);
		wr(eil_pkg::OFF_STATUS_CONTROL, 32'h4);
		brk <= 1'b0;
		low <= 1'b0;
		cyc(4);
		st(32'h0);
		wr(eil_pkg::OFF_BREAK_CONTROL, 32'h0);
	endtask
	// Reset with pin held low
	task automatic t_rst();
		wr(eil_pkg::OFF_STATUS_CONTROL, 32'h3);
		low <= 1'b1;
		cyc(8);
		st(32'hb);
		rst <= 1'b1;
		cyc(2);
		chk("req", 32'h0, {31'h0, req});
		rst <= 1'b0;
		st(32'h0);
		low <= 1'b0;
	endtask
	// Main sequence
	initial begin
		cyc(2);
		rst <= 1'b0;
		t_reset();
		t_ibit();
		t_edge();
		t_mask();
		t_mode1();
		t_brk();
		t_rst();
		end_sim();
	end
endmodule // tb_eil_top
